//--- src/csr_pkg.sv
// Purpose: Constants and types for the configuration and signature readout block
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes:   Overview below lists the behaviour the block keeps
//
// Overview of operation
// [R1] Signature table is read-only; byte index internally, word index for programmers.
// [R2] Table bytes: sig0, trim8, sig1, trim4, sig2, reserved at indices 0..5.
// [R3] Every reset copies the 8 MHz trim byte into the oscillator trim register.
// [R4] The 4 MHz trim is never auto-loaded; software writes it itself.
// [R5] Identification bytes stay readable to programmers even when locked.
// [R6] Identification bytes sit at indices 0..2 in their own space.
// [R7] Fuse and lock reads return zero for programmed and one for unprogrammed.
// [R8] Fuse/lock-read armed, load within three cycles at index 1 returns lock bits.
// [R9] Fuse/lock-read bits clear on completion, no load in three, no store in four.
// [R10] With arm bits clear, loads return ordinary program memory.
// [R11] Fuse/lock mode: index 0 low fuse, 3 high fuse, 2 extended fuse.
// [R12] Signature-read armed, load within three cycles returns the indexed table byte.
// [R13] Signature-read bits self-clear three cycles after being set.
// [R14] Software waits three cycles before using a signature load result.
// [R15] Flash word address splits into in-page word and page fields by part size.
// [R16] EEPROM uses 4-byte pages; page field width depends on part size.
// [R17] Fuse values latch at power-up; later changes apply after the next latch.

package csr_pkg;

  // --------------------------------------------------------------------------
  // Table layout and identity
  // --------------------------------------------------------------------------
  localparam logic [2:0] SIG0_IDX    = 3'h0;
  localparam logic [2:0] TRIM8_IDX   = 3'h1;
  localparam logic [2:0] SIG1_IDX    = 3'h2;
  localparam logic [2:0] TRIM4_IDX   = 3'h3;
  localparam logic [2:0] SIG2_IDX    = 3'h4;
  localparam logic [2:0] RSVD_IDX    = 3'h5;
  localparam int         TABLE_DEPTH = 6;
  // Identity bytes: arbitrary neutral values
  localparam logic [7:0] ID_BYTE0    = 8'h5a;
  localparam logic [7:0] ID_BYTE1    = 8'h21;
  localparam logic [7:0] ID_BYTE2    = 8'h33;
  localparam logic [7:0] RSVD_BYTE   = 8'hff;
  localparam logic [7:0] TRIM_RESET  = 8'h80;

  // --------------------------------------------------------------------------
  // Fuse and lock readout indices
  // --------------------------------------------------------------------------
  localparam logic [15:0] FUSE_LOW_IDX  = 16'h0000;
  localparam logic [15:0] LOCK_IDX      = 16'h0001;
  localparam logic [15:0] FUSE_EXT_IDX  = 16'h0002;
  localparam logic [15:0] FUSE_HIGH_IDX = 16'h0003;
  localparam logic [7:0]  FUSE_UNPROG   = 8'hff;

  // --------------------------------------------------------------------------
  // Timing windows in CPU cycles
  // --------------------------------------------------------------------------
  localparam logic [2:0] LOAD_WINDOW  = 3'h3;
  localparam logic [2:0] STORE_WINDOW = 3'h4;

  // --------------------------------------------------------------------------
  // Address split widths
  // --------------------------------------------------------------------------
  localparam int FLASH_WORD_W_SMALL = 4;
  localparam int FLASH_WORD_W_LARGE = 5;
  localparam int PAGE_FIELD_W       = 6;
  localparam int EE_BYTE_W          = 2;
  localparam int EE_PAGE_W_SMALL    = 5;
  localparam int EE_PAGE_W_LARGE    = 6;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_FUSE = 2'b01,
    MODE_SIG  = 2'b10
  } csr_mode_type;

  typedef struct packed {
    logic [7:0] lock_bits;
    logic [7:0] fuse_low_byte;
    logic [7:0] fuse_high_byte;
    logic [7:0] fuse_ext_byte;
  } csr_fuse_type;

  typedef struct packed {
    logic [5:0] page_select_field;
    logic [4:0] word_in_page_field;
  } csr_flash_split_type;

  typedef struct packed {
    logic [5:0] page_select_field;
    logic [1:0] byte_in_page;
  } csr_ee_split_type;

endpackage : csr_pkg

//--- src/csr_sig_rom.sv
// Purpose: Read-only signature and calibration table, registered read data
// Assumes: Contents fixed by parameters
// Notes:   No write path exists
`timescale 1ns/1ps
`default_nettype none

module csr_sig_rom #(
  parameter logic [7:0] TRIM8_VAL = 8'h80,
  parameter logic [7:0] TRIM4_VAL = 8'h80
) (
  input  wire logic       sys_clk,
  input  wire logic [2:0] rd_idx,
  output logic      [7:0] rd_data
);

  // --------------------------------------------------------------------------
  // Table lookup
  // --------------------------------------------------------------------------
  function automatic logic [7:0] table_byte(input logic [2:0] idx);
    // [R2] table byte layout
    case (idx)
      csr_pkg::SIG0_IDX:  table_byte = csr_pkg::ID_BYTE0;
      csr_pkg::TRIM8_IDX: table_byte = TRIM8_VAL;
      csr_pkg::SIG1_IDX:  table_byte = csr_pkg::ID_BYTE1;
      csr_pkg::TRIM4_IDX: table_byte = TRIM4_VAL;
      csr_pkg::SIG2_IDX:  table_byte = csr_pkg::ID_BYTE2;
      default:            table_byte = csr_pkg::RSVD_BYTE;
    endcase
  endfunction : table_byte

  // [R1] read-only table
  always_ff @(posedge sys_clk) begin
    rd_data <= table_byte(rd_idx);
  end

endmodule : csr_sig_rom

`default_nettype wire

//--- src/csr_readout.sv
// Purpose: Fuse, lock and signature readout through program-memory loads
// Assumes: CPU gives one-cycle load and store strobes with a 16-bit index
// Notes:   Load result appears two cycles after the load strobe
`timescale 1ns/1ps
`default_nettype none

module csr_readout #(
  parameter logic       LARGE_PART = 1'b0,
  parameter logic [7:0] TRIM8_VAL  = 8'h80,
  parameter logic [7:0] TRIM4_VAL  = 8'h80
) (
  input  wire logic                         sys_clk,
  input  wire logic                         srst,
  input  wire logic                         power_up,
  input  wire csr_pkg::csr_fuse_type        fuse_in,
  input  wire logic                         ctrl_wr,
  input  wire logic                         fuse_lock_read_sel,
  input  wire logic                         sig_table_read_sel,
  input  wire logic                         self_prog_enable,
  input  wire logic                         trim_wr,
  input  wire logic [7:0]                   trim_wdata,
  input  wire logic                         load_req,
  input  wire logic                         store_req,
  input  wire logic [15:0]                  load_index,
  input  wire logic [7:0]                   prog_mem_data,
  input  wire logic [2:0]                   prog_sig_idx,
  input  wire logic [10:0]                  flash_word_addr,
  input  wire logic [7:0]                   ee_addr,
  output logic      [7:0]                   load_data,
  output logic                              load_valid,
  output logic                              enable_status,
  output logic      [1:0]                   mode_status,
  output logic      [7:0]                   osc_trim_reg,
  output logic      [7:0]                   prog_sig_data,
  output csr_pkg::csr_flash_split_type      flash_split,
  output csr_pkg::csr_ee_split_type         ee_split
);

  csr_pkg::csr_mode_type mode_reg;
  logic [2:0]            age_reg;
  logic                  trim_loaded_reg;
  logic                  load_pend_reg;
  csr_pkg::csr_mode_type load_mode_reg;
  logic [15:0]           load_idx_reg;
  csr_pkg::csr_fuse_type fuse_latch_reg;
  logic [7:0]            rom_data;
  logic [2:0]            rom_idx;
  logic                  window_open;

  // --------------------------------------------------------------------------
  // Table memory
  // --------------------------------------------------------------------------
  // [R3] trim index during reset
  assign rom_idx = (srst || !trim_loaded_reg) ? csr_pkg::TRIM8_IDX : load_index[2:0];

  csr_sig_rom #(
    .TRIM8_VAL (TRIM8_VAL),
    .TRIM4_VAL (TRIM4_VAL)
  ) u_rom (
    .sys_clk (sys_clk),
    .rd_idx  (rom_idx),
    .rd_data (rom_data)
  );

  // --------------------------------------------------------------------------
  // Fuse latch
  // --------------------------------------------------------------------------
  // [R17] latch on power-up only
  always_ff @(posedge sys_clk) begin
    if (power_up) begin
      fuse_latch_reg <= fuse_in;
    end
  end

  // --------------------------------------------------------------------------
  // Arm bits and window
  // --------------------------------------------------------------------------
  assign window_open = (age_reg < csr_pkg::LOAD_WINDOW);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_reg <= csr_pkg::MODE_IDLE;
      age_reg  <= 3'h0;
    end else if (ctrl_wr && self_prog_enable && fuse_lock_read_sel) begin
      mode_reg <= csr_pkg::MODE_FUSE;
      age_reg  <= 3'h0;
    end else if (ctrl_wr && self_prog_enable && sig_table_read_sel) begin
      mode_reg <= csr_pkg::MODE_SIG;
      age_reg  <= 3'h0;
    end else if (mode_reg == csr_pkg::MODE_FUSE) begin
      // [R9] clear on load or timeout
      if (load_req && window_open) begin
        mode_reg <= csr_pkg::MODE_IDLE;
      end else if (age_reg + 3'h1 >= csr_pkg::STORE_WINDOW) begin
        // Store hold lasts one extra cycle only, so the age never wraps
        mode_reg <= csr_pkg::MODE_IDLE;
      end else if (age_reg + 3'h1 >= csr_pkg::LOAD_WINDOW && !store_req) begin
        mode_reg <= csr_pkg::MODE_IDLE;
      end
      age_reg <= age_reg + 3'h1;
    end else if (mode_reg == csr_pkg::MODE_SIG) begin
      // [R13] self-clear after three
      if (age_reg + 3'h1 >= csr_pkg::LOAD_WINDOW) begin
        mode_reg <= csr_pkg::MODE_IDLE;
      end
      age_reg <= age_reg + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      enable_status <= 1'b0;
      mode_status   <= 2'b00;
    end else begin
      enable_status <= (mode_reg != csr_pkg::MODE_IDLE);
      mode_status   <= mode_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Load capture and result
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      load_pend_reg <= 1'b0;
      load_mode_reg <= csr_pkg::MODE_IDLE;
      load_idx_reg  <= 16'h0000;
    end else begin
      load_pend_reg <= load_req;
      load_idx_reg  <= load_index;
      // [R10] normal load when idle
      load_mode_reg <= (load_req && window_open) ? mode_reg : csr_pkg::MODE_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      load_data  <= 8'h00;
      load_valid <= 1'b0;
    end else begin
      load_valid <= load_pend_reg;
      case (load_mode_reg)
        csr_pkg::MODE_FUSE: begin
          // [R7] [R8] [R11] fuse and lock select
          case (load_idx_reg)
            csr_pkg::FUSE_LOW_IDX:  load_data <= fuse_latch_reg.fuse_low_byte;
            csr_pkg::LOCK_IDX:      load_data <= fuse_latch_reg.lock_bits;
            csr_pkg::FUSE_EXT_IDX:  load_data <= fuse_latch_reg.fuse_ext_byte;
            csr_pkg::FUSE_HIGH_IDX: load_data <= fuse_latch_reg.fuse_high_byte;
            default:                load_data <= csr_pkg::FUSE_UNPROG;
          endcase
        end
        // [R12] table byte readout
        csr_pkg::MODE_SIG: load_data <= rom_data;
        default:           load_data <= prog_mem_data;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Oscillator trim
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      trim_loaded_reg <= 1'b0;
      osc_trim_reg    <= csr_pkg::TRIM_RESET;
    end else if (!trim_loaded_reg) begin
      // [R3] copy 8 MHz trim
      trim_loaded_reg <= 1'b1;
      osc_trim_reg    <= rom_data;
    end else if (trim_wr) begin
      // [R4] software-only trim update
      osc_trim_reg <= trim_wdata;
    end
  end

  // --------------------------------------------------------------------------
  // Programmer identity read
  // --------------------------------------------------------------------------
  // [R5] [R6] readable regardless of lock
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prog_sig_data <= 8'h00;
    end else begin
      case (prog_sig_idx)
        3'h0:    prog_sig_data <= csr_pkg::ID_BYTE0;
        3'h1:    prog_sig_data <= csr_pkg::ID_BYTE1;
        3'h2:    prog_sig_data <= csr_pkg::ID_BYTE2;
        default: prog_sig_data <= csr_pkg::RSVD_BYTE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Address splits
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flash_split <= '0;
      ee_split    <= '0;
    end else if (LARGE_PART) begin
      // [R15] larger part split
      flash_split.word_in_page_field <= flash_word_addr[4:0];
      flash_split.page_select_field  <= flash_word_addr[10:5];
      // [R16] 256-byte EEPROM
      ee_split.byte_in_page          <= ee_addr[1:0];
      ee_split.page_select_field     <= ee_addr[7:2];
    end else begin
      // [R15] smaller part split
      flash_split.word_in_page_field <= {1'b0, flash_word_addr[3:0]};
      flash_split.page_select_field  <= flash_word_addr[9:4];
      // [R16] 128-byte EEPROM
      ee_split.byte_in_page          <= ee_addr[1:0];
      ee_split.page_select_field     <= {1'b0, ee_addr[6:2]};
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_sig_clear;
    @(posedge sys_clk) disable iff (srst)
    (mode_reg == csr_pkg::MODE_SIG && age_reg == 3'h0) |-> ##3 (mode_reg != csr_pkg::MODE_SIG);
  endproperty
  a_sig_clear: assert property (p_sig_clear) else $error("sig mode did not clear"); // [R13]

  property p_fuse_timeout;
    @(posedge sys_clk) disable iff (srst)
    (mode_reg == csr_pkg::MODE_FUSE && age_reg == 3'h0 && !ctrl_wr) |-> ##[1:4] (mode_reg == csr_pkg::MODE_IDLE);
  endproperty
  a_fuse_timeout: assert property (p_fuse_timeout) else $error("fuse mode stuck"); // [R9]

  property p_lock_read;
    @(posedge sys_clk) disable iff (srst)
    (mode_reg == csr_pkg::MODE_FUSE && window_open && load_req && load_index == csr_pkg::LOCK_IDX)
      |-> ##2 (load_valid && load_data == fuse_latch_reg.lock_bits);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock read wrong"); // [R8]

  property p_normal_load;
    @(posedge sys_clk) disable iff (srst)
    (mode_reg == csr_pkg::MODE_IDLE && load_req) |-> ##2 (load_data == $past(prog_mem_data, 1));
  endproperty
  a_normal_load: assert property (p_normal_load) else $error("normal load wrong"); // [R10]

  property p_trim_boot;
    @(posedge sys_clk) $fell(srst) |-> ##2 (osc_trim_reg == TRIM8_VAL);
  endproperty
  a_trim_boot: assert property (p_trim_boot) else $error("trim not loaded"); // [R3]

  property p_trim_hold;
    @(posedge sys_clk) disable iff (srst)
    (trim_loaded_reg && !trim_wr) |=> $stable(osc_trim_reg);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim changed alone"); // [R4]

  property p_fuse_low;
    @(posedge sys_clk) disable iff (srst)
    (mode_reg == csr_pkg::MODE_FUSE && window_open && load_req && load_index == csr_pkg::FUSE_LOW_IDX)
      |-> ##2 (load_data == fuse_latch_reg.fuse_low_byte);
  endproperty
  a_fuse_low: assert property (p_fuse_low) else $error("low fuse wrong"); // [R11]

  property p_prog_id;
    @(posedge sys_clk) disable iff (srst)
    (prog_sig_idx == 3'h1) |=> (prog_sig_data == csr_pkg::ID_BYTE1);
  endproperty
  a_prog_id: assert property (p_prog_id) else $error("id byte wrong"); // [R6]

  c_sig_read: cover property (@(posedge sys_clk) mode_reg == csr_pkg::MODE_SIG && load_req);
  c_fuse_read: cover property (@(posedge sys_clk) mode_reg == csr_pkg::MODE_FUSE && load_req);
  c_timeout: cover property (@(posedge sys_clk) mode_reg == csr_pkg::MODE_FUSE ##3 mode_reg == csr_pkg::MODE_IDLE);
  c_store_hold: cover property (@(posedge sys_clk) mode_reg == csr_pkg::MODE_FUSE && store_req);

endmodule : csr_readout

`default_nettype wire

//--- testbench/csr_cpu_model.sv
// Purpose: CPU core model issuing control writes, stores and program-memory loads
// Assumes: Drives on the falling edge of sys_clk
// Notes:   Program memory byte is held steady through each load
`timescale 1ns/1ps
`default_nettype none

module csr_cpu_model (
  input  wire logic        sys_clk,
  input  wire logic        load_valid,
  input  wire logic [7:0]  load_data,
  output logic             ctrl_wr,
  output logic             fuse_lock_read_sel,
  output logic             sig_table_read_sel,
  output logic             self_prog_enable,
  output logic             load_req,
  output logic             store_req,
  output logic [15:0]      load_index,
  output logic [7:0]       prog_mem_data
);
  initial begin
    ctrl_wr = 1'b0;
    fuse_lock_read_sel = 1'b0;
    sig_table_read_sel = 1'b0;
    self_prog_enable = 1'b0;
    load_req = 1'b0;
    store_req = 1'b0;
    load_index = 16'h0000;
    prog_mem_data = 8'h00;
  end

  task automatic arm(input logic fuse, input logic sig);
    @(negedge sys_clk);
    ctrl_wr = 1'b1;
    fuse_lock_read_sel = fuse;
    sig_table_read_sel = sig;
    self_prog_enable = 1'b1;
    @(negedge sys_clk);
    ctrl_wr = 1'b0;
    fuse_lock_read_sel = ~fuse;
    sig_table_read_sel = ~sig;
    self_prog_enable = 1'b0;
  endtask : arm

  task automatic store;
    @(negedge sys_clk);
    store_req = 1'b1;
    @(negedge sys_clk);
    store_req = 1'b0;
  endtask : store

  task automatic load(input logic [15:0] idx, input int gap, input logic [7:0] mem,
                      output logic [7:0] data, output logic ok);
    repeat (gap - 1) @(negedge sys_clk);
    prog_mem_data = mem;
    load_index = idx;
    load_req = 1'b1;
    @(negedge sys_clk);
    load_req = 1'b0;
    ok = 1'b0;
    data = 8'h00;
    for (int i = 0; i < 6 && !ok; i++) begin
      @(negedge sys_clk);
      if (load_valid === 1'b1) begin
        ok = 1'b1;
        data = load_data;
      end
    end
    load_index = ~idx;
    prog_mem_data = ~mem;
    repeat (3) @(negedge sys_clk);
  endtask : load
endmodule : csr_cpu_model
`default_nettype wire

//--- testbench/tb.sv
// Purpose: Self-checking bench for the readout block
// Assumes: Small part split, trim values set by parameters
// Notes:   Random stimulus from a fixed seed plus corner cases
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam logic [7:0] TRIM8 = 8'h4c;
  localparam logic [7:0] TRIM4 = 8'hb3;
  logic                  sys_clk = 1'b0;
  logic                  srst, power_up, trim_wr, ok;
  logic                  ctrl_wr, fsel, ssel, spen, load_req, store_req, load_valid;
  logic                  enable_status;
  logic [1:0]            mode_status;
  logic [7:0]            trim_wdata, prog_mem_data, ee_addr, load_data, osc_trim_reg;
  logic [7:0]            prog_sig_data, mem, got;
  logic [2:0]            prog_sig_idx;
  logic [10:0]           flash_word_addr;
  logic [15:0]           load_index;
  csr_pkg::csr_fuse_type fuse_in, fuse_lat;
  csr_pkg::csr_flash_split_type flash_split;
  csr_pkg::csr_ee_split_type    ee_split;
  csr_pkg::csr_flash_split_type flash_split_l;
  csr_pkg::csr_ee_split_type    ee_split_l;
  logic                  en_at_valid;
  int                    fails = 0;
  int                    comparisons = 0;

  always #50 sys_clk = ~sys_clk;

  csr_readout #(.LARGE_PART(1'b0), .TRIM8_VAL(TRIM8), .TRIM4_VAL(TRIM4)) i_csr_readout (
    .sys_clk(sys_clk), .srst(srst), .power_up(power_up), .fuse_in(fuse_in),
    .ctrl_wr(ctrl_wr), .fuse_lock_read_sel(fsel), .sig_table_read_sel(ssel),
    .self_prog_enable(spen), .trim_wr(trim_wr), .trim_wdata(trim_wdata),
    .load_req(load_req), .store_req(store_req), .load_index(load_index),
    .prog_mem_data(prog_mem_data), .prog_sig_idx(prog_sig_idx),
    .flash_word_addr(flash_word_addr), .ee_addr(ee_addr), .load_data(load_data),
    .load_valid(load_valid), .enable_status(enable_status), .mode_status(mode_status),
    .osc_trim_reg(osc_trim_reg), .prog_sig_data(prog_sig_data),
    .flash_split(flash_split), .ee_split(ee_split));

  csr_cpu_model i_csr_cpu_model (
    .sys_clk(sys_clk), .load_valid(load_valid), .load_data(load_data), .ctrl_wr(ctrl_wr),
    .fuse_lock_read_sel(fsel), .sig_table_read_sel(ssel), .self_prog_enable(spen),
    .load_req(load_req), .store_req(store_req), .load_index(load_index),
    .prog_mem_data(prog_mem_data));

  // Larger part, watched only for its address splits
  csr_readout #(.LARGE_PART(1'b1), .TRIM8_VAL(TRIM8), .TRIM4_VAL(TRIM4)) i_csr_readout_large (
    .sys_clk(sys_clk), .srst(srst), .power_up(power_up), .fuse_in(fuse_in),
    .ctrl_wr(ctrl_wr), .fuse_lock_read_sel(fsel), .sig_table_read_sel(ssel),
    .self_prog_enable(spen), .trim_wr(trim_wr), .trim_wdata(trim_wdata),
    .load_req(load_req), .store_req(store_req), .load_index(load_index),
    .prog_mem_data(prog_mem_data), .prog_sig_idx(prog_sig_idx),
    .flash_word_addr(flash_word_addr), .ee_addr(ee_addr), .load_data(),
    .load_valid(), .enable_status(), .mode_status(), .osc_trim_reg(), .prog_sig_data(),
    .flash_split(flash_split_l), .ee_split(ee_split_l));

  // Arm state seen in the cycle a load result appears
  always @(negedge sys_clk) begin
    if (load_valid === 1'b1) begin
      en_at_valid <= enable_status;
    end
  end

  // ----------------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] exp_fuse(input logic [15:0] idx, input csr_pkg::csr_fuse_type f);
    case (idx)
      16'h0000: return f.fuse_low_byte;
      16'h0001: return f.lock_bits;
      16'h0002: return f.fuse_ext_byte;
      16'h0003: return f.fuse_high_byte;
      default:  return 8'hff;
    endcase
  endfunction : exp_fuse

  function automatic logic [7:0] exp_sig(input logic [2:0] idx);
    case (idx)
      3'h0:    return csr_pkg::ID_BYTE0;
      3'h1:    return TRIM8;
      3'h2:    return csr_pkg::ID_BYTE1;
      3'h3:    return TRIM4;
      3'h4:    return csr_pkg::ID_BYTE2;
      default: return csr_pkg::RSVD_BYTE;
    endcase
  endfunction : exp_sig

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic do_reset;
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (4) @(negedge sys_clk);
    srst = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : do_reset

  task automatic latch_fuses;
    @(negedge sys_clk);
    power_up = 1'b1;
    @(negedge sys_clk);
    power_up = 1'b0;
  endtask : latch_fuses

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    power_up = 1'b0;
    trim_wr = 1'b0;
    trim_wdata = 8'h00;
    prog_sig_idx = 3'h0;
    flash_word_addr = 11'h000;
    ee_addr = 8'h00;
    fuse_in = '1;
    void'($urandom(32'ha62f));
    do_reset();
    check("trim after reset", TRIM8, osc_trim_reg);
    fuse_lat = $urandom;
    fuse_lat.lock_bits = 8'h00;
    fuse_in = fuse_lat;
    latch_fuses();
    fuse_in = ~fuse_lat;
    for (int i = 0; i < 3; i++) begin
      prog_sig_idx = i[2:0];
      repeat (2) @(negedge sys_clk);
      check("programmer id", exp_sig(3'(2 * i)), prog_sig_data);
    end
    for (int i = 0; i < 6; i++) begin
      mem = 8'($urandom);
      i_csr_cpu_model.arm(1'b1, 1'b0);
      i_csr_cpu_model.load(16'(i), 1 + i % 2, mem, got, ok);
      check("fuse load valid", 8'h01, {7'h00, ok});
      check("fuse load data", exp_fuse(16'(i), fuse_lat), got);
      check("fuse arm cleared", 8'h00, {7'h00, en_at_valid});
    end
    for (int i = 0; i < 6; i++) begin
      i_csr_cpu_model.arm(1'b0, 1'b1);
      i_csr_cpu_model.load(16'(i), 1 + i % 2, 8'($urandom), got, ok);
      check("table load data", exp_sig(i[2:0]), got);
    end
    for (int i = 0; i < 20; i++) begin
      mem = 8'($urandom);
      if (i % 4 == 1) i_csr_cpu_model.arm(1'b1, 1'b0);
      if (i % 4 == 3) i_csr_cpu_model.arm(1'b0, 1'b1);
      i_csr_cpu_model.load(16'($urandom_range(5)), (i % 2) ? 6 : 1, mem, got, ok);
      check("plain load data", mem, got);
    end
    i_csr_cpu_model.arm(1'b0, 1'b1);
    @(negedge sys_clk);
    check("table arm set", 8'h01, {7'h00, enable_status});
    repeat (5) @(negedge sys_clk);
    check("table arm cleared", 8'h00, {7'h00, enable_status});
    // Store lands on the last load cycle and holds the arm one more cycle
    i_csr_cpu_model.arm(1'b1, 1'b0);
    @(negedge sys_clk);
    i_csr_cpu_model.store();
    @(negedge sys_clk);
    check("fuse arm store hold", 8'h01, {7'h00, enable_status});
    repeat (6) @(negedge sys_clk);
    check("fuse arm timeout", 8'h00, {7'h00, enable_status});
    latch_fuses();
    i_csr_cpu_model.arm(1'b1, 1'b0);
    i_csr_cpu_model.load(16'h0000, 1, 8'h00, got, ok);
    check("relatched low fuse", exp_fuse(16'h0000, ~fuse_lat), got);
    i_csr_cpu_model.arm(1'b0, 1'b1);
    i_csr_cpu_model.load(16'h0003, 1, 8'h00, got, ok);
    check("trim before write", TRIM8, osc_trim_reg);
    @(negedge sys_clk);
    trim_wr = 1'b1;
    trim_wdata = got;
    @(negedge sys_clk);
    trim_wr = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("trim written", TRIM4, osc_trim_reg);
    do_reset();
    check("trim reloaded", TRIM8, osc_trim_reg);
    for (int i = 0; i < 12; i++) begin
      flash_word_addr = (i == 0) ? 11'h3ff : (i == 1) ? 11'h7ff : 11'($urandom);
      ee_addr = (i == 0) ? 8'h7f : 8'($urandom);
      repeat (2) @(negedge sys_clk);
      check("flash word", {4'h0, flash_word_addr[3:0]},
            {3'h0, flash_split.word_in_page_field});
      check("flash page", {2'h0, flash_word_addr[9:4]},
            {2'h0, flash_split.page_select_field});
      check("ee byte", {6'h00, ee_addr[1:0]}, {6'h00, ee_split.byte_in_page});
      check("ee page", {3'h0, ee_addr[6:2]}, {2'h0, ee_split.page_select_field});
      check("large flash word", {3'h0, flash_word_addr[4:0]},
            {3'h0, flash_split_l.word_in_page_field});
      check("large flash page", {2'h0, flash_word_addr[10:5]},
            {2'h0, flash_split_l.page_select_field});
      check("large ee byte", {6'h00, ee_addr[1:0]}, {6'h00, ee_split_l.byte_in_page});
      check("large ee page", {2'h0, ee_addr[7:2]}, {2'h0, ee_split_l.page_select_field});
    end
    wrap_up();
  end
endmodule : tb
`default_nettype wire
